// file: rtl/_unused_marker.sv
`timescale 1ns/1ps

// file: rtl/msb_pkg.sv
// Constants, timing figures and carrier types for the media status and backup link block.
// Assumes one 250 MHz clock and pins that arrive asynchronously to it.
// How it works
// - Strap pin or configuration bit selects direct fiber or differential module mode.
// - In module mode, fiber data passes only while signal detect is above threshold.
// - After power-up the backup strap is sampled; high sets backup disable.
// - Management may overwrite backup disable after power-up; the written value is used.
// - After power-up the backup pin turns output and drives high to enable.
// - Copper speed indicator: high at 100Mbps, low at 10Mbps, else released.
// - Fiber speed indicator: high at 100Mbps, low at 10Mbps, else released.
// - Copper speed released: activity pin pulls low during auto-negotiation reception.
// - Copper speed driven: activity pin pulls low while a packet is detected.
// - Packet indication is stretched to a minimum between 1.3 and 2.7 ms.
// - In every other case the activity pin stays released.
// - All logic, stretch timing included, runs on the one reference clock.
package msb_pkg;

	// Clock rate
	localparam real CLK_MHZ = 250.0;

	// Stretch window of the activity indication, in milliseconds
	localparam real STRETCH_MIN_MS = 1.3;
	localparam real STRETCH_MAX_MS = 2.7;
	localparam int STRETCH_MIN_CYC = int'($ceil(STRETCH_MIN_MS * 1000.0 * CLK_MHZ));
	localparam int STRETCH_MAX_CYC = int'($floor(STRETCH_MAX_MS * 1000.0 * CLK_MHZ));

	// Settling time before the backup strap is read, in microseconds
	localparam real STRAP_WAIT_US = 2.0;
	localparam int STRAP_WAIT_CYC = int'($ceil(STRAP_WAIT_US * CLK_MHZ));
	localparam int STRAP_WAIT_W = 10;

	// Mode encoding and reset values
	localparam logic FIBER_MODE_DIRECT = 1'h0;
	localparam logic FIBER_MODE_DIFF = 1'h1;
	localparam logic BKP_DIS_RST = 1'h1;

	// Power-up sequencer states
	typedef enum logic [2:0] {
		ST_WAIT = 3'h1,
		ST_LOAD = 3'h2,
		ST_RUN = 3'h4
	} msb_state_t;

	// Asynchronous pin levels that pass the synchroniser together
	typedef struct packed {
		logic fiber_sd;
		logic mode_strap;
		logic bkp_strap;
		logic cu_100;
		logic cu_10;
		logic cu_an;
		logic cu_pkt;
		logic fo_100;
		logic fo_10;
		logic fo_data;
	} msb_pins_t;

	localparam int PIN_W = $bits(msb_pins_t);

endpackage

// file: rtl/msb_top.sv
// Media status and backup link logic: signal-detect gating, backup strap, speed and activity indicators.
// Assumes all receiver status levels arrive asynchronously; the tri-state pins are resolved outside.
`timescale 1ns/1ps

module msb_top #(
	parameter int STRETCH_CYCLES = msb_pkg::STRETCH_MIN_CYC,
	parameter int CNT_W = 20
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic fiber_signal_detect_in_i,
	input wire logic fiber_interface_mode_select_i,
	input wire logic cfg_fiber_mode_bit_i,
	input wire logic fiber_rx_data_i,
	input wire logic backup_link_strap_in_i,
	input wire logic mgmt_bkp_we_i,
	input wire logic mgmt_bkp_wdata_i,
	input wire logic copper_rx_100_i,
	input wire logic copper_rx_10_i,
	input wire logic copper_rx_an_i,
	input wire logic copper_rx_pkt_i,
	input wire logic fiber_rx_100_i,
	input wire logic fiber_rx_10_i,
	output logic fiber_rx_gated_o,
	output logic fiber_mode_o,
	output logic backup_function_disable_o,
	output logic backup_link_strap_out_o,
	output logic backup_link_strap_oe_o,
	output logic copper_rx_speed_ind_o,
	output logic copper_rx_speed_ind_oe_o,
	output logic fiber_rx_speed_ind_o,
	output logic fiber_rx_speed_ind_oe_o,
	output logic copper_neg_activity_ind_o,
	output logic copper_neg_activity_ind_oe_o
);

	localparam int W = msb_pkg::PIN_W;

	// Refuse a zero stretch, a stretch above the window maximum, or a counter too narrow for it
	if (CNT_W < 1 || CNT_W > 30 || STRETCH_CYCLES < 1 || STRETCH_CYCLES > msb_pkg::STRETCH_MAX_CYC
		|| STRETCH_CYCLES >= (2 ** CNT_W)) begin : g_bad_stretch
		$error("msb_top: STRETCH_CYCLES does not fit the stretch window or the counter");
	end

	msb_pkg::msb_pins_t pin_raw;
	msb_pkg::msb_pins_t pin_f;
	logic [W-1:0] sync1, sync2, sync3, filt, next_filt;

	// Gather the pins into one carrier
	assign pin_raw = '{fiber_sd: fiber_signal_detect_in_i, mode_strap: fiber_interface_mode_select_i,
		bkp_strap: backup_link_strap_in_i, cu_100: copper_rx_100_i, cu_10: copper_rx_10_i,
		cu_an: copper_rx_an_i, cu_pkt: copper_rx_pkt_i, fo_100: fiber_rx_100_i,
		fo_10: fiber_rx_10_i, fo_data: fiber_rx_data_i};
	assign pin_f = filt;

	// Level accepted only when the second and third stages agree, which hides a metastable settle
	for (genvar g = 0; g < W; g++) begin : g_sync
		always_comb begin
			next_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
		end
	end

	// Synchroniser stages; the first stage feeds only the second
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt <= '0;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
		end
	end

	// Fiber mode and signal-detect gating
	logic next_mode, next_gated;
	always_comb begin
		next_mode = (pin_f.mode_strap | cfg_fiber_mode_bit_i) ? msb_pkg::FIBER_MODE_DIFF
			: msb_pkg::FIBER_MODE_DIRECT;
		next_gated = pin_f.fo_data & ((fiber_mode_o == msb_pkg::FIBER_MODE_DIRECT) | pin_f.fiber_sd);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fiber_mode_o <= msb_pkg::FIBER_MODE_DIRECT;
			fiber_rx_gated_o <= 1'h0;
		end else begin
			fiber_mode_o <= next_mode;
			fiber_rx_gated_o <= next_gated;
		end
	end

	// Power-up sequencer: let the strap settle, load it once, then turn the pin round
	msb_pkg::msb_state_t state, next_state;
	logic [msb_pkg::STRAP_WAIT_W-1:0] wait_cnt, next_wait_cnt;
	logic next_bkp_dis, next_bkp_oe;
	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		next_bkp_dis = backup_function_disable_o;
		next_bkp_oe = backup_link_strap_oe_o;
		unique case (state)
			msb_pkg::ST_WAIT: begin
				next_wait_cnt = wait_cnt + 1'h1;
				if (wait_cnt == msb_pkg::STRAP_WAIT_W'(msb_pkg::STRAP_WAIT_CYC - 1))
					next_state = msb_pkg::ST_LOAD;
			end
			msb_pkg::ST_LOAD: begin
				next_bkp_dis = pin_f.bkp_strap;
				next_state = msb_pkg::ST_RUN;
			end
			msb_pkg::ST_RUN: begin
				next_bkp_oe = 1'h1;
				if (mgmt_bkp_we_i)
					next_bkp_dis = mgmt_bkp_wdata_i;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= msb_pkg::ST_WAIT;
			wait_cnt <= '0;
			backup_function_disable_o <= msb_pkg::BKP_DIS_RST;
			backup_link_strap_oe_o <= 1'h0;
			backup_link_strap_out_o <= 1'h0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			backup_function_disable_o <= next_bkp_dis;
			backup_link_strap_oe_o <= next_bkp_oe;
			backup_link_strap_out_o <= ~next_bkp_dis; // High enables the secondary converter
		end
	end

	// Speed indicators and activity stretch; one clock serves all of it
	logic next_cu_spd, next_cu_spd_oe, next_fo_spd, next_fo_spd_oe, next_act_oe;
	logic [CNT_W-1:0] stretch_cnt, next_stretch_cnt;
	logic stretch_on;
	always_comb begin
		next_cu_spd_oe = pin_f.cu_100 | pin_f.cu_10;
		next_cu_spd = pin_f.cu_100;
		next_fo_spd_oe = pin_f.fo_100 | pin_f.fo_10;
		next_fo_spd = pin_f.fo_100;
		// Reload while the packet lasts so the window counts from its end
		if (pin_f.cu_pkt)
			next_stretch_cnt = CNT_W'(STRETCH_CYCLES);
		else if (stretch_cnt != '0)
			next_stretch_cnt = stretch_cnt - 1'h1;
		else
			next_stretch_cnt = '0;
		stretch_on = pin_f.cu_pkt | (stretch_cnt != '0);
		// Pull low for negotiation when speed released, for packets when driven, else release
		next_act_oe = next_cu_spd_oe ? stretch_on : pin_f.cu_an;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			copper_rx_speed_ind_o <= 1'h0;
			copper_rx_speed_ind_oe_o <= 1'h0;
			fiber_rx_speed_ind_o <= 1'h0;
			fiber_rx_speed_ind_oe_o <= 1'h0;
			copper_neg_activity_ind_o <= 1'h0;
			copper_neg_activity_ind_oe_o <= 1'h0;
			stretch_cnt <= '0;
		end else begin
			copper_rx_speed_ind_o <= next_cu_spd;
			copper_rx_speed_ind_oe_o <= next_cu_spd_oe;
			fiber_rx_speed_ind_o <= next_fo_spd;
			fiber_rx_speed_ind_oe_o <= next_fo_spd_oe;
			copper_neg_activity_ind_o <= 1'h0; // Open-drain: only ever pulls low
			copper_neg_activity_ind_oe_o <= next_act_oe;
			stretch_cnt <= next_stretch_cnt;
		end
	end

	// Checks on the driven behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	property p_mode_direct_pass;
		(fiber_mode_o == msb_pkg::FIBER_MODE_DIRECT) |=> (fiber_rx_gated_o == $past(pin_f.fo_data));
	endproperty
	a_mode_direct_pass: assert property (p_mode_direct_pass) else $error("direct mode did not pass data");

	property p_sd_reject;
		(fiber_mode_o == msb_pkg::FIBER_MODE_DIFF && !pin_f.fiber_sd) |=> !fiber_rx_gated_o;
	endproperty
	a_sd_reject: assert property (p_sd_reject) else $error("data passed without signal detect");

	property p_strap_load;
		(state == msb_pkg::ST_LOAD) |=> (backup_function_disable_o == $past(pin_f.bkp_strap)) && !backup_link_strap_oe_o;
	endproperty
	a_strap_load: assert property (p_strap_load) else $error("strap not loaded into disable");

	property p_mgmt_write;
		(state == msb_pkg::ST_RUN && mgmt_bkp_we_i) |=> (backup_function_disable_o == $past(mgmt_bkp_wdata_i));
	endproperty
	a_mgmt_write: assert property (p_mgmt_write) else $error("management write not applied");

	property p_pin_output;
		(state == msb_pkg::ST_LOAD) ##1 1'b1 |=> backup_link_strap_oe_o [*3];
	endproperty
	a_pin_output: assert property (p_pin_output) else $error("backup pin not turned to output");

	property p_cu_speed;
		1'b1 |=> (copper_rx_speed_ind_oe_o == $past(pin_f.cu_100 | pin_f.cu_10))
			&& (!copper_rx_speed_ind_oe_o || copper_rx_speed_ind_o == $past(pin_f.cu_100));
	endproperty
	a_cu_speed: assert property (p_cu_speed) else $error("copper speed indicator wrong");

	property p_fo_speed;
		1'b1 |=> (fiber_rx_speed_ind_oe_o == $past(pin_f.fo_100 | pin_f.fo_10))
			&& (!fiber_rx_speed_ind_oe_o || fiber_rx_speed_ind_o == $past(pin_f.fo_100));
	endproperty
	a_fo_speed: assert property (p_fo_speed) else $error("fiber speed indicator wrong");

	property p_an_low;
		(!pin_f.cu_100 && !pin_f.cu_10 && pin_f.cu_an) |=> copper_neg_activity_ind_oe_o && !copper_neg_activity_ind_o;
	endproperty
	a_an_low: assert property (p_an_low) else $error("negotiation not shown");

	property p_pkt_low;
		((pin_f.cu_100 || pin_f.cu_10) && pin_f.cu_pkt) |=> copper_neg_activity_ind_oe_o;
	endproperty
	a_pkt_low: assert property (p_pkt_low) else $error("packet not shown");

	property p_stretch_hold;
		((pin_f.cu_100 || pin_f.cu_10) && stretch_cnt != '0) |=> copper_neg_activity_ind_oe_o;
	endproperty
	a_stretch_hold: assert property (p_stretch_hold) else $error("stretch ended early");

	property p_release;
		((pin_f.cu_100 || pin_f.cu_10) ? !stretch_on : !pin_f.cu_an) |=> !copper_neg_activity_ind_oe_o;
	endproperty
	a_release: assert property (p_release) else $error("activity pin not released");

	property p_restart;
		pin_f.cu_pkt |=> (stretch_cnt == CNT_W'(STRETCH_CYCLES));
	endproperty
	a_restart: assert property (p_restart) else $error("stretch timer not restarted");

endmodule

// file: testbench/msb_link_model.sv
// Far-side model: activity LED pull-up, backup strap resistor and the enable input of the second converter.
// Assumes the design's output enables are high while it drives a pin.
`timescale 1ns/1ps

module msb_link_model (
	input wire logic strap_level_i,
	input wire logic bkp_val_i,
	input wire logic bkp_oe_i,
	input wire logic act_val_i,
	input wire logic act_oe_i,
	output logic bkp_pin_o,
	output logic act_pin_o,
	output logic second_enable_o
);
	// The strap resistor sets the level only while the device leaves the pin released
	assign bkp_pin_o = bkp_oe_i ? bkp_val_i : strap_level_i;
	// The pull-up turns the LED off when the pin is released, so no stale level lingers
	assign act_pin_o = act_oe_i ? act_val_i : 1'h1;
	// The second converter takes over only on a driven high; used in forced 100M, no loopback
	assign second_enable_o = bkp_oe_i & bkp_val_i;
endmodule

// file: testbench/test_media_status_and_backup_link.sv
// Self-checking bench for the media status and backup link block.
// Assumes msb_top with a short stretch count and msb_link_model on the far side.
`timescale 1ns/1ps

module test_media_status_and_backup_link;
	localparam int STRETCH = 20;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic sd = 1'h0, msel = 1'h0, cfg = 1'h0, fdata = 1'h0, strap = 1'h0, we = 1'h0, wd = 1'h0;
	logic c100 = 1'h0, c10 = 1'h0, can = 1'h0, cpkt = 1'h0, f100 = 1'h0, f10 = 1'h0;
	logic gated, fmode, bdis, bout, boe, cspd, cspd_oe, fspd, fspd_oe, act, act_oe;
	logic bkp_pin, act_pin, sec_en;
	int fails = 0;
	int comparisons = 0;

	// Free-running 250 MHz clock
	always #2 clk = ~clk;

	msb_top #(.STRETCH_CYCLES(STRETCH), .CNT_W(20)) i_dut (.clk_i(clk), .resetn_i(resetn),
		.fiber_signal_detect_in_i(sd), .fiber_interface_mode_select_i(msel), .cfg_fiber_mode_bit_i(cfg),
		.fiber_rx_data_i(fdata), .backup_link_strap_in_i(bkp_pin), .mgmt_bkp_we_i(we),
		.mgmt_bkp_wdata_i(wd), .copper_rx_100_i(c100), .copper_rx_10_i(c10), .copper_rx_an_i(can),
		.copper_rx_pkt_i(cpkt), .fiber_rx_100_i(f100), .fiber_rx_10_i(f10), .fiber_rx_gated_o(gated),
		.fiber_mode_o(fmode), .backup_function_disable_o(bdis), .backup_link_strap_out_o(bout),
		.backup_link_strap_oe_o(boe), .copper_rx_speed_ind_o(cspd), .copper_rx_speed_ind_oe_o(cspd_oe),
		.fiber_rx_speed_ind_o(fspd), .fiber_rx_speed_ind_oe_o(fspd_oe), .copper_neg_activity_ind_o(act),
		.copper_neg_activity_ind_oe_o(act_oe));

	msb_link_model i_link (.strap_level_i(strap), .bkp_val_i(bout), .bkp_oe_i(boe), .act_val_i(act),
		.act_oe_i(act_oe), .bkp_pin_o(bkp_pin), .act_pin_o(act_pin), .second_enable_o(sec_en));

	task automatic check(input string what, input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", what, exp, seen);
		end
	endtask

	// Inputs always change 1 ns after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Power-up with a given strap level; the pin stays released until the strap is read
	task automatic t_strap(input logic lvl);
		resetn = 1'h0;
		strap = lvl;
		tick(16);
		check("disable in reset", bdis, 1'h1);
		resetn = 1'h1;
		tick(495);
		check("backup oe before load", boe, 1'h0);
		// A write while the strap still settles must be ignored
		we = 1'h1;
		wd = 1'h0;
		tick(1);
		we = 1'h0;
		check("early write ignored", bdis, 1'h1);
		tick(14);
		check("backup disable", bdis, lvl);
		check("backup oe", boe, 1'h1);
		check("second enable", sec_en, ~lvl);
		$display("test strap %b done", lvl);
	endtask

	// Back-to-back management writes, each used on the next edge
	task automatic t_write;
		we = 1'h1;
		wd = 1'h1;
		tick(1);
		check("write 1 disable", bdis, 1'h1);
		check("write 1 enable", sec_en, 1'h0);
		wd = 1'h0;
		tick(1);
		check("write 0 disable", bdis, 1'h0);
		check("write 0 pin", bkp_pin, 1'h1);
		we = 1'h0;
		$display("test write done");
	endtask

	// Every mode source against every detect and data level
	task automatic t_gate;
		logic m;
		for (int i = 0; i < 16; i++) begin
			{msel, cfg, sd, fdata} = i[3:0];
			tick(10);
			m = msel | cfg;
			check("fiber mode", fmode, m);
			check("gated data", gated, fdata & (~m | sd));
		end
		$display("test gate done");
	endtask

	// Speed indicators and negotiation indication with no packets
	task automatic t_speed;
		for (int i = 0; i < 8; i++) begin
			{can, c100, c10} = i[2:0];
			{f100, f10} = i[1:0];
			tick(8);
			check("copper speed oe", cspd_oe, c100 | c10);
			check("fiber speed oe", fspd_oe, f100 | f10);
			if (c100 | c10) begin
				check("copper speed", cspd, c100);
				check("fiber speed", fspd, f100);
			end
			check("activity pin", act_pin, ~(can & ~(c100 | c10)));
		end
		{can, c100, c10, f100, f10} = 5'h00;
		$display("test speed done");
	endtask

	// Stretched packet indication, then two more packets, the later one restarting the stretch of the earlier
	task automatic t_stretch;
		cpkt = 1'h1;
		tick(8);
		check("packet while released", act_oe, 1'h0);
		c100 = 1'h1;
		tick(8);
		check("packet shown", act_pin, 1'h0);
		cpkt = 1'h0;
		tick(STRETCH);
		check("stretched", act_oe, 1'h1);
		tick(12);
		check("stretch ends", act_pin, 1'h1);
		cpkt = 1'h1;
		tick(2);
		cpkt = 1'h0;
		tick(15);
		cpkt = 1'h1;
		tick(2);
		cpkt = 1'h0;
		tick(STRETCH);
		check("restarted", act_oe, 1'h1);
		tick(12);
		check("restart ends", act_oe, 1'h0);
		$display("test stretch done");
	endtask

	// Main sequence
	initial begin
		t_strap(1'h1);
		t_strap(1'h0);
		t_write;
		t_gate;
		t_speed;
		t_stretch;
		stop_test;
	end

	// Watchdog well beyond the expected run of about 1400 cycles
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule
